// ==== core/i2gc_core.sv ====
// Two-wire port core: slave address match with general call and mask,
// address hold, and master start/restart/stop/receive/ack sequences.
// Assumes APB from software and open-drain SCL/SDA sampled on pclk.
`timescale 1ns/10ps
module i2gc_core (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [i2gc_pkg::AW-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  scl_i,
    output logic                       scl_o,
    output logic                       scl_oe,
    input  wire logic                  sda_i,
    output logic                       sda_o,
    output logic                       sda_oe,
    output logic                       irq
);
    import i2gc_pkg::*;

    logic       scl_s, sda_s, scl_p_r, sda_p_r;
    logic [7:0] ctl1_r, ctl2_r, own_r, msk_r, buf_r, div_r, div_cnt_r;
    logic       address_hold_enable_r, ua_r;
    logic [3:0] ist_r, imsk_r;
    i2gc_sst_t  s_st_r, s_nxt_r;
    logic [3:0] s_cnt_r;
    logic [7:0] s_sr_r;
    logic       s_scl_r, s_sda_r, s_addr_ev, s_gc_ev, s_data_ev;
    logic       s_cap_r, s_ua_set;
    i2gc_mst_t  m_st_r;
    logic [1:0] m_ph_r, m_kind_r;
    logic [3:0] m_cnt_r;
    logic [8:0] m_sh_r;
    logic [4:0] m_cmd_r;
    logic       m_scl_r, m_sda_r, m_done_r;

    i2gc_sync u_scl (.clk(pclk), .rst_n(presetn), .d(scl_i), .q(scl_s));
    i2gc_sync u_sda (.clk(pclk), .rst_n(presetn), .d(sda_i), .q(sda_s));

    // Line edges and bus conditions
    wire scl_rise = scl_s & ~scl_p_r;
    wire scl_fall = ~scl_s & scl_p_r;
    wire start_c  = scl_s & scl_p_r & sda_p_r & ~sda_s;
    wire stop_c   = scl_s & scl_p_r & ~sda_p_r & sda_s;

    // APB decode
    wire       wr_en  = psel & penable & pready & pwrite;
    wire       setup  = psel & ~penable;
    wire       a_ctl1 = paddr == OFS_CTL1;
    wire       a_ctl2 = paddr == OFS_CTL2;
    wire       a_ctl3 = paddr == OFS_CTL3;
    wire       a_own  = paddr == OFS_OWN;
    wire       a_msk  = paddr == OFS_MSK;
    wire       a_buf  = paddr == OFS_BUF;
    wire       a_stat = paddr == OFS_STAT;
    wire       a_ist  = paddr == OFS_IST;
    wire       a_imsk = paddr == OFS_IMSK;
    wire       a_div  = paddr == OFS_DIV;
    wire       hit    = a_ctl1 | a_ctl2 | a_ctl3 | a_own | a_msk | a_buf
                      | a_stat | a_ist | a_imsk | a_div;
    wire [7:0] wd     = pwdata[7:0];

    wire mst_on = ctl1_r[C1_EN] & ctl1_r[C1_MST];
    wire slv_on = ctl1_r[C1_EN] & ~ctl1_r[C1_MST];
    wire ten    = ctl1_r[C1_TEN];
    wire s_busy = (s_st_r != S_IDLE) & (s_st_r != S_IGN);

    // Busy while a master sequence runs or is pending, or a slave transfer
    wire port_idle = (m_st_r == M_IDLE) & ~(mst_on & (|ctl2_r[4:0]))
                   & ~s_busy;

    wire [7:0] stat = {4'h0, s_busy | (m_st_r != M_IDLE),
                       s_st_r == S_HOLD, ua_r, port_idle};
    wire [7:0] rd8  = a_ctl1 ? ctl1_r :
                      a_ctl2 ? ctl2_r :
                      a_ctl3 ? {7'h0, address_hold_enable_r} :
                      a_own  ? own_r :
                      a_msk  ? msk_r :
                      a_buf  ? buf_r :
                      a_stat ? stat :
                      a_ist  ? {4'h0, ist_r} :
                      a_imsk ? {4'h0, imsk_r} :
                      a_div  ? div_r : 8'h00;

    // Master request selection; lowest bit (start) has priority
    wire [4:0] req     = ctl2_r[4:0] & {5{mst_on}};
    wire [4:0] pick    = (m_st_r == M_IDLE) ? (req & (~req + 5'h01)) : 5'h0;
    wire       tx_go   = wr_en & a_buf & port_idle & mst_on;
    wire       tick    = (m_st_r != M_IDLE) & (div_cnt_r == 8'h00);
    wire       m_fin   = tick & (m_ph_r == 2'd3)
                       & ((m_st_r != M_BITS) | (m_cnt_r == 4'd1));
    wire [4:0] fin_clr = m_fin ? m_cmd_r : 5'h0;
    wire [4:0] en_nxt  = (wr_en & a_ctl2 & port_idle) ? wd[4:0]
                       : (ctl2_r[4:0] & ~fin_clr);
    i2gc_mst_t m_launch;
    assign m_launch = pick[0] ? M_START :
                      pick[1] ? M_RSTART :
                      pick[2] ? M_STOP : M_BITS;

    // Slave address comparison
    wire [7:0] xr     = s_sr_r ^ own_r;
    wire       gc_hit = ctl2_r[C2_GENERAL_CALL_ENABLE] & (s_sr_r == GC_ADDR);
    wire       m7     = ~ten & ((xr[7:1] & msk_r[7:1]) == 7'h00);
    wire       hi10   = ten & (s_sr_r[7:3] == TEN_HDR)
                      & (s_sr_r[2:1] == ctl1_r[C1_HI +: 2]) & ~s_sr_r[0];
    wire       lo10   = (xr & msk_r) == 8'h00;
    wire       rel_wr = wr_en & a_ctl3 & wd[C3_REL];
    wire [3:0] ev     = {s_gc_ev, m_done_r, s_data_ev, s_addr_ev};
    wire [3:0] w1c    = (wr_en & a_ist) ? wd[3:0] : 4'h0;

    // APB slave: one wait-free access phase; data latched in setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup & ~hit;
            if (setup)
                prdata <= {24'h0, rd8};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl1_r <= CTL1_RST;
            address_hold_enable_r <= 1'b0;
            own_r  <= OWN_RST;
            msk_r  <= MSK_RST;
            imsk_r <= IMSK_RST;
            div_r  <= DIV_RST;
        end
        else if (wr_en)
        begin
            if (a_ctl1) ctl1_r <= wd;
            if (a_ctl3) address_hold_enable_r <= wd[C3_ADDRESS_HOLD_ENABLE];
            if (a_own)  own_r  <= wd;
            if (a_msk)  msk_r  <= wd;
            if (a_imsk) imsk_r <= wd[3:0];
            if (a_div)  div_r  <= wd;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctl2_r <= CTL2_RST;
        else
        begin
            if (wr_en & a_ctl2)
            begin
                ctl2_r[C2_GENERAL_CALL_ENABLE]  <= wd[C2_GENERAL_CALL_ENABLE];
                ctl2_r[C2_ACKNOWLEDGE_DATA_BIT] <= wd[C2_ACKNOWLEDGE_DATA_BIT];
            end
            ctl2_r[4:0] <= en_nxt;
            if (m_fin & (m_kind_r == K_TX))
                ctl2_r[C2_ACKST] <= m_sh_r[0];
        end
    end

    // Buffer: slave capture, master receive, then software write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            buf_r <= 8'h00;
        else if (s_cap_r)
            buf_r <= s_sr_r;
        else if (m_fin & (m_kind_r == K_RX))
            buf_r <= m_sh_r[7:0];
        else if (wr_en & a_buf & port_idle)
            buf_r <= wd;
    end

    // Sticky events: a set in the same cycle as a clear wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ist_r <= 4'h0;
            ua_r  <= 1'b0;
            irq   <= 1'b0;
        end
        else
        begin
            ist_r <= (ist_r & ~w1c) | ev;
            ua_r  <= (ua_r & ~(wr_en & a_own)) | s_ua_set;
            irq   <= |(ist_r & imsk_r);
        end
    end

    // Quarter-bit enable for the master sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_cnt_r <= DIV_RST;
        else if ((m_st_r == M_IDLE) | (div_cnt_r == 8'h00))
            div_cnt_r <= div_r;
        else
            div_cnt_r <= div_cnt_r - 8'h01;
    end

    // Master sequencer; four quarter phases per bit or condition.
    // Clock stretching by a far slave is not honoured.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            m_st_r   <= M_IDLE;
            m_ph_r   <= 2'd0;
            m_cnt_r  <= 4'd0;
            m_sh_r   <= 9'h1ff;
            m_kind_r <= K_TX;
            m_cmd_r  <= 5'h0;
            m_scl_r  <= 1'b0;
            m_sda_r  <= 1'b0;
            m_done_r <= 1'b0;
        end
        else
        begin
            m_done_r <= m_fin;
            if (!mst_on)
            begin
                m_st_r  <= M_IDLE;
                m_scl_r <= 1'b0;
                m_sda_r <= 1'b0;
            end
            else if (m_st_r == M_IDLE)
            begin
                m_ph_r <= 2'd0;
                if (|pick)
                begin
                    m_cmd_r  <= pick;
                    m_st_r   <= m_launch;
                    m_kind_r <= pick[3] ? K_RX : K_ACK;
                    m_cnt_r  <= pick[4] ? 4'd1 : 4'd8;
                    m_sh_r   <= pick[4] ? {ctl2_r[C2_ACKNOWLEDGE_DATA_BIT], 8'hff}
                                        : 9'h1ff;
                end
                else if (tx_go)
                begin
                    m_cmd_r  <= 5'h0;
                    m_st_r   <= M_BITS;
                    m_kind_r <= K_TX;
                    m_cnt_r  <= 4'd9;
                    m_sh_r   <= {wd, 1'b1};
                end
            end
            else if (tick)
            begin
                m_ph_r <= m_ph_r + 2'd1;
                unique case (m_st_r)
                    M_START:
                    begin
                        if (m_ph_r == 2'd0) m_scl_r <= 1'b0;
                        if (m_ph_r == 2'd0) m_sda_r <= 1'b0;
                        if (m_ph_r == 2'd2) m_sda_r <= 1'b1;
                        if (m_ph_r == 2'd3) m_scl_r <= 1'b1;
                    end
                    M_RSTART:
                    begin
                        if (m_ph_r == 2'd0) m_sda_r <= 1'b0;
                        if (m_ph_r == 2'd1) m_scl_r <= 1'b0;
                        if (m_ph_r == 2'd2) m_sda_r <= 1'b1;
                        if (m_ph_r == 2'd3) m_scl_r <= 1'b1;
                    end
                    M_STOP:
                    begin
                        if (m_ph_r == 2'd0) m_sda_r <= 1'b1;
                        if (m_ph_r == 2'd1) m_scl_r <= 1'b0;
                        if (m_ph_r == 2'd2) m_sda_r <= 1'b0;
                    end
                    M_BITS:
                    begin
                        if (m_ph_r == 2'd0) m_scl_r <= 1'b1;
                        if (m_ph_r == 2'd0) m_sda_r <= ~m_sh_r[8];
                        if (m_ph_r == 2'd1) m_scl_r <= 1'b0;
                        if (m_ph_r == 2'd2) m_sh_r <= {m_sh_r[7:0], sda_s};
                        if (m_ph_r == 2'd3) m_scl_r <= 1'b1;
                        if (m_ph_r == 2'd3) m_cnt_r <= m_cnt_r - 4'd1;
                    end
                    default:
                        m_st_r <= M_IDLE;
                endcase
                if (m_fin)
                    m_st_r <= M_IDLE;
            end
        end
    end

    // Slave receiver: address match, hold, acknowledge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_st_r    <= S_IDLE;
            s_nxt_r   <= S_IDLE;
            s_cnt_r   <= 4'd0;
            s_sr_r    <= 8'h00;
            s_scl_r   <= 1'b0;
            s_sda_r   <= 1'b0;
            s_addr_ev <= 1'b0;
            s_gc_ev   <= 1'b0;
            s_data_ev <= 1'b0;
            s_cap_r   <= 1'b0;
            s_ua_set  <= 1'b0;
        end
        else
        begin
            s_addr_ev <= 1'b0;
            s_gc_ev   <= 1'b0;
            s_data_ev <= 1'b0;
            s_cap_r   <= 1'b0;
            s_ua_set  <= 1'b0;
            if (!slv_on | stop_c)
            begin
                s_st_r  <= S_IDLE;
                s_scl_r <= 1'b0;
                s_sda_r <= 1'b0;
            end
            else if (start_c)
            begin
                s_st_r  <= S_ADDR;
                s_cnt_r <= 4'd0;
                s_scl_r <= 1'b0;
                s_sda_r <= 1'b0;
            end
            else
            begin
                unique case (s_st_r)
                    S_ADDR, S_ADDR2, S_DATA:
                    begin
                        if (scl_rise & (s_cnt_r != 4'd8))
                        begin
                            s_sr_r  <= {s_sr_r[6:0], sda_s};
                            s_cnt_r <= s_cnt_r + 4'd1;
                        end
                        else if (scl_fall & (s_cnt_r == 4'd8))
                        begin
                            if ((s_st_r == S_ADDR) & (gc_hit | m7 | hi10))
                            begin
                                s_addr_ev <= 1'b1;
                                s_gc_ev   <= gc_hit;
                                s_ua_set  <= hi10 & ~gc_hit;
                                s_nxt_r   <= hi10 ? S_ADDR2 :
                                             (s_sr_r[0] ? S_IGN : S_DATA);
                                s_st_r    <= address_hold_enable_r ? S_HOLD : S_ACK;
                                s_scl_r   <= address_hold_enable_r;
                                s_sda_r   <= ~address_hold_enable_r;
                            end
                            else if ((s_st_r == S_ADDR2) & lo10)
                            begin
                                s_addr_ev <= 1'b1;
                                s_nxt_r   <= S_DATA;
                                s_st_r    <= address_hold_enable_r ? S_HOLD : S_ACK;
                                s_scl_r   <= address_hold_enable_r;
                                s_sda_r   <= ~address_hold_enable_r;
                            end
                            else if (s_st_r == S_DATA)
                            begin
                                s_cap_r   <= 1'b1;
                                s_data_ev <= 1'b1;
                                s_nxt_r   <= S_DATA;
                                s_st_r    <= ctl2_r[C2_SEN] ? S_HOLD : S_ACK;
                                s_scl_r   <= ctl2_r[C2_SEN];
                                s_sda_r   <= ~ctl2_r[C2_SEN];
                            end
                            else
                                s_st_r <= S_IGN;
                        end
                    end
                    S_HOLD:
                        if (rel_wr)
                        begin
                            s_scl_r <= 1'b0;
                            s_sda_r <= ~ctl2_r[C2_ACKNOWLEDGE_DATA_BIT];
                            s_st_r  <= S_ACK;
                        end
                    S_ACK:
                        if (scl_fall)
                        begin
                            s_sda_r <= 1'b0;
                            s_cnt_r <= 4'd0;
                            s_st_r  <= s_nxt_r;
                        end
                    S_IDLE, S_IGN:
                        s_st_r <= s_st_r;
                    default:
                        s_st_r <= S_IDLE;
                endcase
            end
        end
    end

    // Open-drain pins: level always low, enable pulls the wire
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scl_p_r <= 1'b1;
            sda_p_r <= 1'b1;
            scl_oe  <= 1'b0;
            sda_oe  <= 1'b0;
            scl_o   <= 1'b0;
            sda_o   <= 1'b0;
        end
        else
        begin
            scl_p_r <= scl_s;
            sda_p_r <= sda_s;
            scl_oe  <= mst_on ? m_scl_r : s_scl_r;
            sda_oe  <= mst_on ? m_sda_r : s_sda_r;
            scl_o   <= 1'b0;
            sda_o   <= 1'b0;
        end
    end
endmodule

// ==== core/i2gc_pkg.sv ====
// Shared constants for the two-wire port core: register map, bit fields,
// reset values, timing counts and state encodings.
// Assumes APB byte addresses with one 32-bit word per register.
package i2gc_pkg;
    localparam int AW = 8;

    localparam logic [7:0] OFS_CTL1 = 8'h00;
    localparam logic [7:0] OFS_CTL2 = 8'h04;
    localparam logic [7:0] OFS_CTL3 = 8'h08;
    localparam logic [7:0] OFS_OWN  = 8'h0c;
    localparam logic [7:0] OFS_MSK  = 8'h10;
    localparam logic [7:0] OFS_BUF  = 8'h14;
    localparam logic [7:0] OFS_STAT = 8'h18;
    localparam logic [7:0] OFS_IST  = 8'h1c;
    localparam logic [7:0] OFS_IMSK = 8'h20;
    localparam logic [7:0] OFS_DIV  = 8'h24;

    // Control one: enable, master mode, 10-bit mode, high address bits
    localparam int C1_EN  = 0;
    localparam int C1_MST = 1;
    localparam int C1_TEN = 2;
    localparam int C1_HI  = 3;
    // Control two
    localparam int C2_GENERAL_CALL_ENABLE  = 7;
    localparam int C2_ACKST = 6;
    localparam int C2_ACKNOWLEDGE_DATA_BIT = 5;
    localparam int C2_ACKNOWLEDGE_SEQUENCE_ENABLE = 4;
    localparam int C2_RECEIVE_ENABLE_BIT  = 3;
    localparam int C2_PEN   = 2;
    localparam int C2_REPEATED_START_ENABLE  = 1;
    localparam int C2_SEN   = 0;
    // Control three: address hold enable, clock release strobe
    localparam int C3_ADDRESS_HOLD_ENABLE = 0;
    localparam int C3_REL  = 1;
    // Status
    localparam int ST_IDLE = 0;
    localparam int ST_UA   = 1;
    localparam int ST_HOLD = 2;
    localparam int ST_BUSY = 3;
    // Interrupt events
    localparam int EV_ADDR = 0;
    localparam int EV_DATA = 1;
    localparam int EV_MDON = 2;
    localparam int EV_GC   = 3;

    localparam logic [7:0] CTL1_RST = 8'h00;
    localparam logic [7:0] CTL2_RST = 8'h00;
    localparam logic [7:0] OWN_RST  = 8'h00;
    localparam logic [7:0] MSK_RST  = 8'hff;
    localparam logic [3:0] IMSK_RST = 4'h0;
    localparam logic [7:0] GC_ADDR  = 8'h00;
    localparam logic [4:0] TEN_HDR  = 5'h1e;

    // Master SCL quarter period, least time, rounded up to cycles
    localparam int CLK_NS      = 10;
    localparam int SCL_QTR_NS  = 2500;
    localparam int QTR_CYC     = (SCL_QTR_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] DIV_RST = 8'(QTR_CYC - 1);

    localparam logic [1:0] K_TX  = 2'h0;
    localparam logic [1:0] K_RX  = 2'h1;
    localparam logic [1:0] K_ACK = 2'h2;

    typedef enum logic [6:0] {
        S_IDLE  = 7'b0000001,
        S_ADDR  = 7'b0000010,
        S_ADDR2 = 7'b0000100,
        S_DATA  = 7'b0001000,
        S_HOLD  = 7'b0010000,
        S_ACK   = 7'b0100000,
        S_IGN   = 7'b1000000
    } i2gc_sst_t;

    typedef enum logic [4:0] {
        M_IDLE   = 5'b00001,
        M_START  = 5'b00010,
        M_RSTART = 5'b00100,
        M_STOP   = 5'b01000,
        M_BITS   = 5'b10000
    } i2gc_mst_t;
endpackage

// ==== core/i2gc_sync.sv ====
// Two-flop synchroniser for one line from outside the pclk domain.
// Resets high because the bus lines idle high.
`timescale 1ns/10ps
module i2gc_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);
    logic meta_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= 1'b1;
            q      <= 1'b1;
        end
        else
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// ==== bench/i2gc_monitor.sv ====
// Checker on the core ports: bus answer timing and wire levels.
// Assumes one pclk domain reset by presetn.
`timescale 1ns/10ps
module i2gc_monitor
    import i2gc_pkg::*;
(
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [i2gc_pkg::AW-1:0] paddr,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire logic                    scl_i,
    input wire logic                    scl_o,
    input wire logic                    sda_o,
    input wire logic                    sda_oe
);
    logic msk_wr_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Until software writes the mask, reads must show the reset value
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            msk_wr_r <= 1'b0;
        else if (psel && penable && pready && pwrite && paddr == OFS_MSK)
            msk_wr_r <= 1'b1;

    a_ready_next: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_unmapped: assert property (pready && paddr > OFS_DIV |-> pslverr)
        else $error("unmapped access not flagged");
    a_err_mapped: assert property (pready && paddr == OFS_CTL2 |-> !pslverr)
        else $error("mapped access flagged");
    a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_mask_reset: assert property (
        pready && !pwrite && paddr == OFS_MSK && !msk_wr_r
        |-> prdata[7:0] == MSK_RST) else $error("mask reset value lost");
    a_open_drain: assert property (!scl_o && !sda_o)
        else $error("line driven high");
    a_ack_steady: assert property ($rose(scl_i) && sda_oe |=> sda_oe)
        else $error("data pull dropped in clock high");

    c_pull: cover property ($rose(sda_oe) && !scl_i);
    c_err: cover property (pready && pslverr);
    c_read: cover property (pready && !pwrite && paddr == OFS_MSK);
endmodule

bind i2gc_core i2gc_monitor u_i2gc_monitor (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_i),
    .scl_o(scl_o), .sda_o(sda_o), .sda_oe(sda_oe));

// ==== bench/i2gc_peer.sv ====
// Bus master model on the far side: start, bytes with ack, stop.
// SCL rests high between frames; the bench pulls both lines up.
`timescale 1ns/10ps
module i2gc_peer (
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_pull,
    output logic      sda_pull
);
    initial scl_pull = 1'b0;
    initial sda_pull = 1'b0;

    // 80 ns a bit, 20 of them high: the long low phase leaves the slave
    // time to answer through its synchroniser; a held SCL stretches it
    task automatic send_bit(input logic b, output logic s);
        begin
            sda_pull = !b;
            #50 scl_pull = 1'b0;
            wait (scl === 1'b1);
            #10 s = sda;
            #10 scl_pull = 1'b1;
            #10;
        end
    endtask

    task automatic frame(input logic [15:0] d, input int n,
                         output logic [1:0] acks);
        logic s;
        begin
            acks = 2'h0;
            sda_pull = 1'b1;
            #20 scl_pull = 1'b1;
            #10;
            for (int i = 0; i < n; i++)
            begin
                for (int k = 15 - 8 * i; k > 7 - 8 * i; k--)
                    send_bit(d[k], s);
                send_bit(1'b1, s);
                acks[i] = !s;
            end
            sda_pull = 1'b1;
            #30 scl_pull = 1'b0;
            #20 sda_pull = 1'b0;
            #40;
        end
    endtask
endmodule

// ==== bench/i2c_general_call_and_mask_test.sv ====
// Bench for the port core: address table, reset, hold, master sequences.
// Assumes the peer model as bus master on a pulled-up wire.
`timescale 1ns/10ps
module i2c_general_call_and_mask_test;
    import i2gc_pkg::*;
    typedef struct {
        logic [7:0]  c1, own, msk, c2;
        logic [15:0] d;
        int          n;
        logic [1:0]  ack;
        logic        gc, ua;
    } i2gc_row_t;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
    logic        penable = 1'b0, pwrite = 1'b0, err, irq, pready, pslverr;
    logic        scl_pull, sda_pull, scl_oe, sda_oe, scl_o, sda_o, scl, sda;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, v;
    logic [1:0]  ack;
    int          num_errors = 0, n_compared = 0, cyc = 0;
    i2gc_row_t   rows [8] = '{
        '{8'h01, 8'ha0, 8'hff, 8'h00, 16'ha000, 1, 2'h1, 1'b0, 1'b0},
        '{8'h01, 8'ha0, 8'hff, 8'h00, 16'ha200, 1, 2'h0, 1'b0, 1'b0},
        '{8'h01, 8'ha0, 8'hfd, 8'h00, 16'ha200, 1, 2'h1, 1'b0, 1'b0},
        '{8'h01, 8'ha0, 8'h7f, 8'h00, 16'h2000, 1, 2'h1, 1'b0, 1'b0},
        '{8'h01, 8'ha0, 8'hff, 8'h80, 16'h0000, 2, 2'h3, 1'b1, 1'b0},
        '{8'h01, 8'ha0, 8'hff, 8'h00, 16'h0000, 1, 2'h0, 1'b0, 1'b0},
        '{8'h05, 8'h34, 8'hff, 8'h80, 16'h0000, 2, 2'h3, 1'b1, 1'b0},
        '{8'h05, 8'h34, 8'hf0, 8'h00, 16'hf03b, 2, 2'h3, 1'b0, 1'b1}};

    assign scl = !((scl_oe && !scl_o) || scl_pull);
    assign sda = !((sda_oe && !sda_o) || sda_pull);
    always #5 pclk = ~pclk;

    i2gc_core u_i2gc_core (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl),
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .irq(irq));
    i2gc_peer u_i2gc_peer (.scl(scl), .sda(sda), .scl_pull(scl_pull),
        .sda_pull(sda_pull));

    task automatic chk(input string nm, input logic [7:0] exp, got);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Request stands until the rising edge that samples pready high
    task automatic apb(input logic w, input logic [7:0] a, d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk);
        while (pready !== 1'b1);
        v = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic results;
        if (num_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            results();
        end
    end

    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, OFS_IMSK, 8'h08);
        foreach (rows[i])
        begin
            apb(1'b1, OFS_CTL1, rows[i].c1);
            apb(1'b1, OFS_OWN, rows[i].own);
            apb(1'b1, OFS_MSK, rows[i].msk);
            apb(1'b1, OFS_CTL2, rows[i].c2);
            u_i2gc_peer.frame(rows[i].d, rows[i].n, ack);
            chk("ack", 8'(rows[i].ack), 8'(ack));
            apb(1'b0, OFS_STAT, 8'h00);
            chk("ua", 8'(rows[i].ua), 8'(v[ST_UA]));
            apb(1'b0, OFS_IST, 8'h00);
            chk("gc", 8'(rows[i].gc), 8'(v[EV_GC]));
            chk("irq", 8'(rows[i].gc), 8'(irq));
            apb(1'b1, OFS_IST, 8'h0f);
        end
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_MSK, 8'h00);
        chk("mask", MSK_RST, v[7:0]);
        apb(1'b0, 8'h40, 8'h00);
        chk("slverr", 8'h01, 8'(err));
        apb(1'b1, OFS_CTL1, 8'h01);
        apb(1'b1, OFS_CTL3, 8'h01);
        apb(1'b1, OFS_CTL2, 8'h80);
        fork
            u_i2gc_peer.frame(16'h0000, 1, ack);
            begin
                wait (scl_oe === 1'b1);
                apb(1'b0, OFS_STAT, 8'h00);
                chk("hold", 8'h01, 8'(v[ST_HOLD]));
                apb(1'b1, OFS_CTL3, 8'h03);
            end
        join
        chk("hold ack", 8'h01, 8'(ack));
        chk("masked", 8'h00, 8'(irq));
        apb(1'b1, OFS_IST, 8'h0f);
        apb(1'b1, OFS_DIV, 8'h01);
        apb(1'b1, OFS_CTL1, 8'h03);
        apb(1'b1, OFS_CTL2, 8'h01);
        apb(1'b1, OFS_CTL2, 8'h04);
        apb(1'b1, OFS_BUF, 8'h5a);
        do apb(1'b0, OFS_STAT, 8'h00);
        while (v[ST_IDLE] !== 1'b1);
        chk("sda held", 8'h01, 8'(sda_oe));
        chk("scl held", 8'h01, 8'(scl_oe));
        apb(1'b0, OFS_BUF, 8'h00);
        chk("buf", 8'h00, v[7:0]);
        apb(1'b0, OFS_CTL2, 8'h00);
        chk("ctl2", 8'h00, 8'(v[4:0]));
        apb(1'b0, OFS_IST, 8'h00);
        chk("done", 8'h01, 8'(v[EV_MDON]));
        apb(1'b1, OFS_CTL2, 8'h04);
        do apb(1'b0, OFS_STAT, 8'h00);
        while (v[ST_IDLE] !== 1'b1);
        chk("stop", 8'h00, 8'(sda_oe));
        apb(1'b1, OFS_CTL2, 8'h10);
        do apb(1'b0, OFS_STAT, 8'h00);
        while (v[ST_IDLE] !== 1'b1);
        chk("ack low", 8'h01, 8'(sda_oe));
        apb(1'b1, OFS_CTL2, 8'h30);
        do apb(1'b0, OFS_STAT, 8'h00);
        while (v[ST_IDLE] !== 1'b1);
        chk("nack", 8'h00, 8'(sda_oe));
        apb(1'b0, OFS_CTL2, 8'h00);
        chk("acknowledge_sequence_enable", 8'h20, v[7:0]);
        results();
    end
endmodule
